// *** bench/cfl_loader_checker.sv ***
// Concurrent checks of the configuration loader at its top ports.
// Assumes binding to cfl_loader; the lock value is rebuilt from accepted lock writes.
`timescale 1ns/10ps
module cfl_loader_checker (
    // Clock and reset
    input wire logic         CLK,
    input wire logic         SRST,
    // Commands
    input wire logic         KEY_WR,
    input wire logic         LOCK_WR,
    input wire logic [127:0] LOCK_IN,
    input wire logic [127:0] PASS_IN,
    input wire logic         S_START,
    input wire logic         S_VALID,
    input wire logic         S_LAST,
    // Status and memory side
    input wire logic         S_READY,
    input wire logic         BUSY,
    input wire logic         KEY_SET,
    input wire logic         LOCK_SET,
    input wire logic         REFUSED,
    input wire logic         DONE,
    input wire logic         AUTH_OK,
    input wire logic         CFG_ERASE,
    input wire logic         CFG_WE
);
    logic [127:0] lock_r;
    logic [127:0] lock_nxt;
    logic         auth;

    assign auth = !LOCK_SET || PASS_IN == lock_r;

    // Key write wins over lock write in the same cycle
    always_comb
    begin
        lock_nxt = lock_r;
        if (LOCK_WR && !KEY_WR && !BUSY && auth)
            lock_nxt = LOCK_IN;
    end

    always_ff @(posedge CLK)
        lock_r <= SRST ? 128'h0 : lock_nxt;

    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    //////////////////////////////////////////////////////////
    a_key_taken: assert property (KEY_WR && !BUSY && auth |=> BUSY && !KEY_SET ##11 KEY_SET && !BUSY)
        else $error("key load timing wrong");
    a_key_refused: assert property (KEY_WR && !BUSY && !auth |=> REFUSED && $stable(KEY_SET))
        else $error("unauthorized key write not refused");
    a_start_refused: assert property
        (S_START && !KEY_WR && !LOCK_WR && !BUSY && !(auth && KEY_SET) |=> REFUSED && !BUSY)
        else $error("unauthorized stream start not refused");
    a_block_gap: assert property
        (S_VALID && S_READY && !S_LAST |=> (!S_READY)[*8] ##1 (!S_READY)[*2] ##1 S_READY)
        else $error("block decipher gap wrong");
    a_done_delay: assert property (S_VALID && S_READY && S_LAST |=> (!DONE)[*8] ##1 (!DONE)[*3] ##1 DONE)
        else $error("check result not on time");
    a_done_pulse: assert property (DONE |=> !DONE)
        else $error("done longer than one cycle");
    a_erase_gate: assert property (CFG_ERASE |-> DONE && AUTH_OK)
        else $error("erase without passed check");
    a_write_order: assert property (CFG_WE && !$past(CFG_WE) |-> $past(CFG_ERASE))
        else $error("write not right after erase");
    a_fail_quiet: assert property (DONE && !AUTH_OK |-> (!CFG_ERASE && !BUSY) ##1 !CFG_WE)
        else $error("memory touched after failed check");
    a_idle_quiet: assert property (!BUSY |-> !CFG_WE && !CFG_ERASE)
        else $error("memory strobe while idle");

    c_pass: cover property (DONE && AUTH_OK);
    c_fail: cover property (DONE && !AUTH_OK);
    c_refuse: cover property (REFUSED);
endmodule

bind cfl_loader cfl_loader_checker i_chk (.CLK(CLK), .SRST(SRST), .KEY_WR(KEY_WR), .LOCK_WR(LOCK_WR),
    .LOCK_IN(LOCK_IN), .PASS_IN(PASS_IN), .S_START(S_START), .S_VALID(S_VALID), .S_LAST(S_LAST),
    .S_READY(S_READY), .BUSY(BUSY), .KEY_SET(KEY_SET), .LOCK_SET(LOCK_SET), .REFUSED(REFUSED),
    .DONE(DONE), .AUTH_OK(AUTH_OK), .CFG_ERASE(CFG_ERASE), .CFG_WE(CFG_WE));

// *** bench/cfl_prog_model.sv ***
// Programming-side model: key, lock and stream commands toward the loader.
// Assumes its tasks are called at a falling edge of CLK.
`timescale 1ns/10ps
module cfl_prog_model (
    // Clock and handshake
    input  wire logic         CLK,
    input  wire logic         S_READY,
    // Commands
    output      logic         KEY_WR,
    output      logic [127:0] KEY_IN,
    output      logic         LOCK_WR,
    output      logic [127:0] LOCK_IN,
    output      logic [127:0] PASS_IN,
    // Stream
    output      logic         S_START,
    output      logic         S_VALID,
    output      logic         S_LAST,
    output      logic [127:0] S_DATA
);
    int gap = 0;    // Idle cycles before each block, for a slow programmer

    initial
    begin
        {KEY_WR, LOCK_WR, S_START, S_VALID, S_LAST} = 5'h0;
        {KEY_IN, LOCK_IN, PASS_IN, S_DATA} = 512'h0;
    end
    //////////////////////////////////////////////////////////
    // Stale values are inverted so nothing old lingers on idle lines
    task automatic key_cmd(input logic [127:0] k);
        KEY_IN = k;
        KEY_WR = 1'h1;
        @(negedge CLK);
        KEY_WR = 1'h0;
        KEY_IN = ~k;
    endtask

    task automatic lock_cmd(input logic [127:0] l);
        LOCK_IN = l;
        LOCK_WR = 1'h1;
        @(negedge CLK);
        LOCK_WR = 1'h0;
        LOCK_IN = ~l;
    endtask

    task automatic set_pass(input logic [127:0] p);
        PASS_IN = p;
    endtask

    task automatic start;
        S_START = 1'h1;
        @(negedge CLK);
        S_START = 1'h0;
    endtask

    task automatic idle;
        S_VALID = 1'h0;
        S_LAST  = 1'h0;
        S_DATA  = ~S_DATA;
    endtask

    // Holds the block until the rising edge that takes it
    task automatic send(input logic [127:0] d, input logic l);
        if (gap > 0)
        begin
            idle();
            repeat (gap) @(negedge CLK);
        end
        S_DATA  = d;
        S_LAST  = l;
        S_VALID = 1'h1;
        while (S_READY !== 1'h1)
            @(negedge CLK);
        @(negedge CLK);
    endtask
endmodule

// *** bench/testbench.sv ***
// Self-checking bench of the configuration loader.
// Assumes the loader, checker and programming model compiled before it.
`timescale 1ns/10ps
module testbench;
    import cfl_pkg::*;
    // Known AES-128 key, plaintext and ciphertext, a second key and a pass key
    localparam logic [127:0] KEY_A  = 128'h000102030405060708090A0B0C0D0E0F;
    localparam logic [127:0] P_A    = 128'h00112233445566778899AABBCCDDEEFF;
    localparam logic [127:0] C_A    = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
    localparam logic [127:0] KEY_B  = 128'h2B7E151628AED2A6ABF7158809CF4F3C;
    localparam logic [127:0] PASS_X = 128'h5A5A_0000_1111_2222_3333_4444_5555_A5A5;

    logic         clk, srst, key_wr, lock_wr, s_start, s_valid, s_last, s_ready;
    logic         busy, key_set, lock_set, refused, done, auth_ok, cfg_erase, cfg_we;
    logic [127:0] key_in, lock_in, pass_in, s_data, cfg_data;
    logic [15:0]  cfg_addr;
    int           err_total = 0;
    int           compares  = 0;
    int           cycles    = 0;

    // Signature is P_A turned right one bit, so two blocks of P_A fold to a tag of P_A
    cfl_loader #(.DEPTH(4), .DEV_SIG({P_A[0], P_A[127:1]})) i_dut (.CLK(clk), .SRST(srst), .KEY_WR(key_wr),
        .KEY_IN(key_in), .LOCK_WR(lock_wr), .LOCK_IN(lock_in), .PASS_IN(pass_in), .S_START(s_start),
        .S_VALID(s_valid), .S_LAST(s_last), .S_DATA(s_data), .S_READY(s_ready), .BUSY(busy),
        .KEY_SET(key_set), .LOCK_SET(lock_set), .REFUSED(refused), .DONE(done), .AUTH_OK(auth_ok),
        .CFG_ERASE(cfg_erase), .CFG_WE(cfg_we), .CFG_ADDR(cfg_addr), .CFG_DATA(cfg_data));
    cfl_prog_model i_prog (.CLK(clk), .S_READY(s_ready), .KEY_WR(key_wr), .KEY_IN(key_in),
        .LOCK_WR(lock_wr), .LOCK_IN(lock_in), .PASS_IN(pass_in), .S_START(s_start),
        .S_VALID(s_valid), .S_LAST(s_last), .S_DATA(s_data));

    initial
    begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    //////////////////////////////////////////////////////////
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("compares %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // A bench this short needs well under 3000 cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic key_load(input logic [127:0] k, input logic ok);
        logic ks;
        ks = key_set;
        i_prog.key_cmd(k);
        check(busy, ok);
        check(refused, !ok);
        check(key_set, ok ? 1'h0 : ks);
        repeat (11) @(negedge clk);
        check(key_set, ok ? 1'h1 : ks);
        check(busy, 1'h0);
    endtask

    task automatic run_stream(input logic [127:0] d, input logic [127:0] t, input int n, input logic ok,
                              input logic [127:0] p);
        i_prog.start();
        repeat (n) i_prog.send(d, 1'h0);
        i_prog.send(t, 1'h1);
        i_prog.idle();
        repeat (11) @(posedge clk);
        @(negedge clk);
        check(done, 1'h1);
        check(auth_ok, ok);
        check(cfg_erase, ok);
        @(negedge clk);
        check(cfg_we, ok);
        if (ok)
        begin
            for (int i = 0; i < n; i++)
            begin
                check(cfg_we, 1'h1);
                check(cfg_addr, 16'(i));
                check(cfg_data, p);
                @(negedge clk);
            end
        end
        check(busy, 1'h0);
    endtask

    task automatic start_refused;
        i_prog.start();
        check(refused, 1'h1);
        check(busy, 1'h0);
    endtask

    task automatic t_reset;
        check({key_set, lock_set, busy, done, auth_ok, s_ready}, 6'h0);
        start_refused();
        $display("test reset done");
    endtask

    task automatic t_streams;
        key_load(KEY_A, 1'h1);
        run_stream(C_A, C_A, 2, 1'h1, P_A);
        run_stream(C_A, C_A ^ 128'h1, 2, 1'h0, P_A);
        run_stream(C_A ^ {1'h1, 127'h0}, C_A, 2, 1'h0, P_A);
        run_stream(C_A, C_A, 1, 1'h0, P_A);
        key_load(KEY_B, 1'h1);
        run_stream(C_A, C_A, 2, 1'h0, P_A);
        key_load(KEY_A, 1'h1);
        i_prog.gap = 3;
        run_stream(C_A, C_A, 2, 1'h1, P_A);
        i_prog.gap = 0;
        $display("test streams done");
    endtask

    task automatic t_lock;
        i_prog.lock_cmd(PASS_X);
        check(lock_set, 1'h1);
        i_prog.set_pass(~PASS_X);
        key_load(KEY_B, 1'h0);
        start_refused();
        i_prog.lock_cmd(128'h0);
        check(refused, 1'h1);
        i_prog.set_pass(PASS_X);
        run_stream(C_A, C_A, 2, 1'h1, P_A);
        key_load(KEY_B, 1'h1);
        run_stream(C_A, C_A, 2, 1'h0, P_A);
        $display("test lock done");
    endtask

    initial
    begin
        srst = 1'h1;
        repeat (12) @(negedge clk);
        srst = 1'h0;
        t_reset();
        t_streams();
        t_lock();
        report_and_stop();
    end
endmodule

// *** hw/cfl_loader.sv ***
// Authenticated configuration loader: key store, lock pass key, AES-128 inverse cipher,
// stream tag check, staging store and the erase/write sequence to configuration memory.
// Assumes all inputs synchronous to CLK and a configuration memory that takes one word per strobe.
`timescale 1ns/10ps
`include "cfl_params.svh"
module cfl_loader
    import cfl_pkg::*;
#(
    parameter int DEPTH = `CFL_STAGE_DEPTH,
    parameter logic [127:0] DEV_SIG = `CFL_DEV_SIG   // Arbitrary value
) (
    // Clock and reset
    input  wire logic         CLK,
    input  wire logic         SRST,
    // Key and lock commands
    input  wire logic         KEY_WR,
    input  wire logic [127:0] KEY_IN,
    input  wire logic         LOCK_WR,
    input  wire logic [127:0] LOCK_IN,
    input  wire logic [127:0] PASS_IN,
    // Encrypted stream
    input  wire logic         S_START,
    input  wire logic         S_VALID,
    input  wire logic         S_LAST,
    input  wire logic [127:0] S_DATA,
    output      logic         S_READY,
    // Status
    output      logic         BUSY,
    output      logic         KEY_SET,
    output      logic         LOCK_SET,
    output      logic         REFUSED,
    output      logic         DONE,
    output      logic         AUTH_OK,
    // Configuration memory
    output      logic         CFG_ERASE,
    output      logic         CFG_WE,
    output      logic [15:0]  CFG_ADDR,
    output      logic [127:0] CFG_DATA
);
    localparam int SAW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || DEPTH > 65536)
        begin : g_bad_depth
            $error("DEPTH out of range");
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////////////////////
    // GF(2^8) arithmetic; S-boxes are computed, not tabled, to keep the area of one round small

    function automatic logic [7:0] xt(input logic [7:0] a);
        return {a[6:0], 1'b0} ^ (a[7] ? `CFL_GF_POLY : 8'h00);
    endfunction

    function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] r;
        p = a;
        r = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            if (b[i])
                r = r ^ p;
            p = xt(p);
        end
        return r;
    endfunction

    function automatic logic [7:0] ginv(input logic [7:0] x);
        logic [7:0] p;
        logic [7:0] r;
        p = x;
        r = 8'h01;
        for (int i = 1; i < 8; i++)
        begin
            p = gmul(p, p);
            r = gmul(r, p);
        end
        return r;
    endfunction

    function automatic logic [7:0] sbox(input logic [7:0] x);
        logic [7:0] y;
        logic [7:0] c;
        logic [7:0] b;
        y = ginv(x);
        c = `CFL_SBOX_C;
        for (int i = 0; i < 8; i++)
            b[i] = y[i] ^ y[(i+4)%8] ^ y[(i+5)%8] ^ y[(i+6)%8] ^ y[(i+7)%8] ^ c[i];
        return b;
    endfunction

    function automatic logic [7:0] isbox(input logic [7:0] x);
        logic [7:0] d;
        logic [7:0] t;
        d = `CFL_ISBOX_C;
        for (int i = 0; i < 8; i++)
            t[i] = x[(i+2)%8] ^ x[(i+5)%8] ^ x[(i+7)%8] ^ d[i];
        return ginv(t);
    endfunction

    function automatic logic [127:0] imix(input logic [127:0] s);
        logic [7:0]   a [4];
        logic [127:0] o;
        o = '0;
        for (int c = 0; c < 4; c++)
        begin
            for (int r = 0; r < 4; r++)
                a[r] = s[127-8*(4*c+r) -: 8];
            for (int r = 0; r < 4; r++)
                o[127-8*(4*c+r) -: 8] = gmul(a[r], 8'h0E) ^ gmul(a[(r+1)%4], 8'h0B)
                                      ^ gmul(a[(r+2)%4], 8'h0D) ^ gmul(a[(r+3)%4], 8'h09);
        end
        return o;
    endfunction

    function automatic logic [127:0] kstep(input logic [127:0] k, input logic [7:0] rc);
        logic [31:0]  t;
        logic [127:0] n;
        t = {sbox(k[23:16]) ^ rc, sbox(k[15:8]), sbox(k[7:0]), sbox(k[31:24])};
        n[127:96] = k[127:96] ^ t;
        n[95:64]  = k[95:64] ^ n[127:96];
        n[63:32]  = k[63:32] ^ n[95:64];
        n[31:0]   = k[31:0] ^ n[63:32];
        return n;
    endfunction

    //////////////////////////////////////////////////////////////////////////////////////////
    // Memories: round keys and staged plaintext

    cfl_mem_if #(.W(`CFL_BLK_W), .AW(`CFL_RK_AW)) rk_bus ();
    cfl_mem_if #(.W(`CFL_BLK_W), .AW(SAW))        st_bus ();

    cfl_mem #(.W(`CFL_BLK_W), .AW(`CFL_RK_AW), .DEPTH(`CFL_RK_NUM)) u_rk_mem
    (
        .clk  (CLK),
        .port (rk_bus.mem)
    );

    cfl_mem #(.W(`CFL_BLK_W), .AW(SAW), .DEPTH(DEPTH)) u_stage_mem
    (
        .clk  (CLK),
        .port (st_bus.mem)
    );

    //////////////////////////////////////////////////////////////////////////////////////////
    // Inverse round datapath

    cfl_state_t   state_r, state_nxt;
    logic [127:0] blk_r, blk_nxt;
    logic [127:0] kx_r, kx_nxt;
    logic [7:0]   rcon_r, rcon_nxt;
    logic [3:0]   rnd_r, rnd_nxt;
    logic [127:0] mac_r, mac_nxt;
    logic [127:0] lock_r, lock_nxt;
    logic         key_ok_r, key_ok_nxt;
    logic         lock_on_r, lock_on_nxt;
    logic [SAW:0] cnt_r, cnt_nxt;
    logic [SAW:0] cp_r, cp_nxt;
    logic         last_r, last_nxt;
    logic         ovf_r, ovf_nxt;
    logic         ref_r, ref_nxt;
    logic         done_r, done_nxt;
    logic         pass_r, pass_nxt;
    logic [127:0] isub;
    logic [127:0] radd;
    logic [127:0] rout;
    logic         auth_cmd;

    genvar gc, gr;
    generate
        for (gc = 0; gc < 4; gc++)
        begin : g_col
            for (gr = 0; gr < 4; gr++)
            begin : g_row
                assign isub[127-8*(4*gc+gr) -: 8] = isbox(blk_r[127-8*(4*((gc-gr+4)%4)+gr) -: 8]);
            end
        end
    endgenerate

    // Round key for round rnd_r sits on rdata because the read address follows rnd_nxt
    assign radd = isub ^ rk_bus.rdata;
    assign rout = (rnd_r == 4'd0) ? radd : imix(radd);

    //////////////////////////////////////////////////////////////////////////////////////////
    // Control

    assign auth_cmd = !lock_on_r || (PASS_IN == lock_r);

    always_comb
    begin
        state_nxt  = state_r;
        blk_nxt    = blk_r;
        kx_nxt     = kx_r;
        rcon_nxt   = rcon_r;
        rnd_nxt    = rnd_r;
        mac_nxt    = mac_r;
        lock_nxt   = lock_r;
        key_ok_nxt = key_ok_r;
        lock_on_nxt = lock_on_r;
        cnt_nxt    = cnt_r;
        cp_nxt     = cp_r;
        last_nxt   = last_r;
        ovf_nxt    = ovf_r;
        ref_nxt    = 1'b0;
        done_nxt   = 1'b0;
        pass_nxt   = pass_r;
        rk_bus.we    = 1'b0;
        rk_bus.waddr = rnd_r;
        rk_bus.wdata = kx_r;
        st_bus.we    = 1'b0;
        st_bus.waddr = cnt_r[SAW-1:0];
        st_bus.wdata = rout;
        case (state_r)
            CFL_IDLE:
            begin
                if (KEY_WR || LOCK_WR || S_START)
                begin
                    if (!auth_cmd || (S_START && !KEY_WR && !LOCK_WR && !key_ok_r))
                    begin
                        ref_nxt = 1'b1;
                    end
                    else if (KEY_WR)
                    begin
                        kx_nxt    = KEY_IN;
                        rcon_nxt  = `CFL_RCON_INIT;
                        rnd_nxt   = 4'd0;
                        key_ok_nxt = 1'b0;
                        state_nxt = CFL_KEYX;
                    end
                    else if (LOCK_WR)
                    begin
                        lock_nxt    = LOCK_IN;
                        lock_on_nxt = 1'b1;
                    end
                    else
                    begin
                        mac_nxt   = DEV_SIG;
                        cnt_nxt   = '0;
                        ovf_nxt   = 1'b0;
                        rnd_nxt   = 4'(`CFL_ROUNDS);
                        state_nxt = CFL_RECV;
                    end
                end
            end
            CFL_KEYX:
            begin
                rk_bus.we = 1'b1;
                kx_nxt    = kstep(kx_r, rcon_r);
                rcon_nxt  = xt(rcon_r);
                rnd_nxt   = rnd_r + 4'd1;
                if (rnd_r == 4'(`CFL_ROUNDS))
                begin
                    key_ok_nxt = 1'b1;
                    state_nxt  = CFL_IDLE;
                    // Park on the last round key; one more step would read past the store
                    rnd_nxt    = 4'(`CFL_ROUNDS);
                end
            end
            CFL_RECV:
            begin
                if (S_VALID)
                begin
                    blk_nxt   = S_DATA ^ rk_bus.rdata;
                    last_nxt  = S_LAST;
                    rnd_nxt   = 4'(`CFL_ROUNDS - 1);
                    state_nxt = CFL_DEC;
                end
            end
            CFL_DEC:
            begin
                blk_nxt = rout;
                rnd_nxt = rnd_r - 4'd1;
                if (rnd_r == 4'd0)
                begin
                    rnd_nxt   = 4'(`CFL_ROUNDS);
                    state_nxt = last_r ? CFL_CHECK : CFL_RECV;
                    if (!last_r)
                    begin
                        // Folding each block keeps the tag bound to block order, not only content
                        mac_nxt = {mac_r[126:0], mac_r[127]} ^ rout;
                        if (cnt_r == (SAW+1)'(DEPTH))
                            ovf_nxt = 1'b1;
                        else
                        begin
                            st_bus.we = 1'b1;
                            cnt_nxt   = cnt_r + 1'b1;
                        end
                    end
                end
            end
            CFL_CHECK:
            begin
                done_nxt = 1'b1;
                cp_nxt   = '0;
                if (blk_r == mac_r && !ovf_r && cnt_r != '0)
                begin
                    pass_nxt  = 1'b1;
                    state_nxt = CFL_ERASE;
                end
                else
                begin
                    pass_nxt  = 1'b0;
                    state_nxt = CFL_IDLE;
                end
            end
            CFL_ERASE:
            begin
                state_nxt = CFL_COPY;
            end
            CFL_COPY:
            begin
                cp_nxt = cp_r + 1'b1;
                if (cp_r + 1'b1 == cnt_r)
                    state_nxt = CFL_IDLE;
            end
            default:
            begin
                state_nxt = CFL_IDLE;
            end
        endcase
    end

    // Read addresses lead by one edge so rdata matches the current round or copy index
    assign rk_bus.raddr = rnd_nxt;
    assign st_bus.raddr = cp_nxt[SAW-1:0];

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            state_r   <= CFL_IDLE;
            blk_r     <= '0;
            kx_r      <= '0;
            rcon_r    <= `CFL_RCON_INIT;
            rnd_r     <= '0;
            mac_r     <= '0;
            lock_r    <= '0;
            key_ok_r  <= 1'b0;
            lock_on_r <= 1'b0;
            cnt_r     <= '0;
            cp_r      <= '0;
            last_r    <= 1'b0;
            ovf_r     <= 1'b0;
            ref_r     <= 1'b0;
            done_r    <= 1'b0;
            pass_r    <= 1'b0;
        end
        else
        begin
            state_r   <= state_nxt;
            blk_r     <= blk_nxt;
            kx_r      <= kx_nxt;
            rcon_r    <= rcon_nxt;
            rnd_r     <= rnd_nxt;
            mac_r     <= mac_nxt;
            lock_r    <= lock_nxt;
            key_ok_r  <= key_ok_nxt;
            lock_on_r <= lock_on_nxt;
            cnt_r     <= cnt_nxt;
            cp_r      <= cp_nxt;
            last_r    <= last_nxt;
            ovf_r     <= ovf_nxt;
            ref_r     <= ref_nxt;
            done_r    <= done_nxt;
            pass_r    <= pass_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    // Outputs; configuration memory gets no erase or write strobe until the check has passed

    assign S_READY   = (state_r == CFL_RECV);
    assign BUSY      = (state_r != CFL_IDLE);
    assign KEY_SET   = key_ok_r;
    assign LOCK_SET  = lock_on_r;
    assign REFUSED   = ref_r;
    assign DONE      = done_r;
    assign AUTH_OK   = pass_r;
    assign CFG_ERASE = (state_r == CFL_ERASE);
    assign CFG_WE    = (state_r == CFL_COPY);
    assign CFG_ADDR  = 16'(cp_r);
    assign CFG_DATA  = st_bus.rdata;
endmodule

// *** hw/cfl_mem.sv ***
// Small word memory with registered read data.
// Assumes synchronous CLK; read data follows the read address by one edge.
`timescale 1ns/10ps
module cfl_mem #(
    parameter int W     = 128,
    parameter int AW    = 4,
    parameter int DEPTH = 11
) (
    input wire logic clk,
    cfl_mem_if.mem   port
);
    logic [W-1:0] store [DEPTH];
    logic [W-1:0] rdata_r;

    always_ff @(posedge clk)
    begin
        if (port.we)
        begin
            store[port.waddr] <= port.wdata;
        end
        rdata_r <= store[port.raddr];
    end

    assign port.rdata = rdata_r;
endmodule

// *** hw/cfl_mem_if.sv ***
// Port bundle between the loader and its word memories.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
interface cfl_mem_if #(parameter int W = 128, parameter int AW = 4);
    logic          we;
    logic [AW-1:0] waddr;
    logic [W-1:0]  wdata;
    logic [AW-1:0] raddr;
    logic [W-1:0]  rdata;

    modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// *** hw/cfl_params.svh ***
// Constants of the authenticated configuration loader: widths, field values, counts.
// Assumes inclusion by bare name from the loader and its package-level users.
//
// How it works
// - The decryption key lives in an on-chip store written only by the key port and no port ever shows its value.
// - Every stream block is deciphered with the stored key only, so only streams made with that key decode correctly.
// - A stream made under another key fails the tag compare and nothing of it reaches configuration memory.
// - A 128-bit AES inverse cipher deciphers each block and the check runs before any erase or write.
// - The check folds every deciphered data block plus the device signature and compares the whole against the tag.
// - Loading runs beside the user logic, which sees no change until the final erase and write sequence.
// - Erase and then the write of the staged contents start only after the whole stream has passed the check.
// - On a failed check no erase or write strobe is given and the current contents stay in service.
// - With the lock pass key set, key, lock and stream commands need the matching pass key presented.
// - A new key write without the correct pass key is refused while the lock is set.
//////////////////////////////////////////////////////////////////////////////////////////////
`ifndef CFL_PARAMS_SVH
`define CFL_PARAMS_SVH

`define CFL_BLK_W       128
`define CFL_ROUNDS      10
`define CFL_RK_NUM      11
`define CFL_RK_AW       4
`define CFL_STAGE_DEPTH 64
`define CFL_SBOX_C      8'h63
`define CFL_ISBOX_C     8'h05
`define CFL_GF_POLY     8'h1B
`define CFL_RCON_INIT   8'h01
`define CFL_DEV_SIG     128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210

`endif

// *** hw/cfl_pkg.sv ***
// Types of the authenticated configuration loader.
// Assumes cfl_params.svh for the numeric constants.
package cfl_pkg;

    typedef enum logic [2:0]
    {
        CFL_IDLE  = 3'b000,
        CFL_KEYX  = 3'b001,
        CFL_RECV  = 3'b010,
        CFL_DEC   = 3'b011,
        CFL_CHECK = 3'b100,
        CFL_ERASE = 3'b101,
        CFL_COPY  = 3'b110
    } cfl_state_t;

endpackage
